//--- include/cycle_logic_map.vh
// Constants for the scan-cycle logic element set: register map, field layout, reset values.
// Assumes a 32-bit APB bus, byte addresses, one aligned word per register.
//
// Notes on behaviour
// - Two analog outputs take only analog inputs, analog flags or outputs; others refused.
// - Twenty-seven digital flags and six analog flags present the value applied.
// - Startup flag is high during the first cycle and cleared after it.
// - After the first cycle the startup flag behaves as an ordinary flag; here it reads low for the second cycle, then as written.
// - Two dedicated flags drive onboard and external display backlights.
// - Character-set flag 0 picks the first set, 1 the second.
// - Unused character-set flag leaves the stored message configuration set in force.
// - Flag outputs show the previous cycle value, steady through the current cycle.
// - Eight shift bits are read-only; only the shift function updates them.
// - Four cursor keys act as inputs in RUN or during an active message.
// - Four function keys of the external display act as inputs in RUN.
// - Constant high, constant low and open sources exist for block inputs.
// - Each gate input may be inverted individually.
// - AND gives 1 only when all inputs are 1; open input counts 1.
// - Edge AND: all 1 now and some input was 0 last cycle.
// - NAND gives 0 only when all inputs are 1; open input counts 1.
// - Edge NAND: some input 0 now and all were 1 last cycle.
// - OR gives 1 when any input is 1; open input counts 0.
`ifndef CYCLE_LOGIC_MAP_VH
`define CYCLE_LOGIC_MAP_VH

// Register byte offsets.
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_CYCLE_DIV  8'h08
`define REG_FLAG_NEXT  8'h0C
`define REG_FLAG_OUT   8'h10
`define REG_SHIFT      8'h14
`define REG_AQ0_SRC    8'h18
`define REG_AQ1_SRC    8'h1C
`define REG_AQ_VAL     8'h20
`define REG_AFLAG_BASE 8'h24
`define REG_GATE_OUT   8'h40
`define REG_GATE_BASE  8'h80
`define REG_AFLAG_END  8'h3C
`define REG_GATE_END   8'hC0

// Control and status fields.
`define CTRL_RUN        0
`define CTRL_STEP       1
`define CTRL_RESTART    2
`define CTRL_CS_USED    3
`define CTRL_CS_CFG     4
`define STAT_FIRST      0
`define STAT_REJECT     1

// Sizes.
`define NUM_FLAGS       27
`define NUM_AFLAGS      6
`define NUM_AFUNC       4
`define NUM_GATES       8
`define AW              16

// Dedicated flag positions.
`define FLAG_STARTUP    7
`define FLAG_BL_ONBOARD 24
`define FLAG_BL_EXT     25
`define FLAG_CHARSET    26

// Analog output source types.
`define AQ_SRC_FUNC     2'h0
`define AQ_SRC_AFLAG    2'h1
`define AQ_SRC_AQ       2'h2

// Gate source codes (6 bits).
`define SRC_OPEN        6'h00
`define SRC_LOW         1
`define SRC_HIGH        2
`define SRC_CURSOR      4
`define SRC_FKEY        8
`define SRC_SHIFT       12
`define SRC_GATE        20
`define SRC_DIN         28
`define SRC_FLAG        32

// Gate types.
`define G_AND           3'h0
`define G_AND_EDGE      3'h1
`define G_NAND          3'h2
`define G_NAND_EDGE     3'h3
`define G_OR            3'h4

// Reset values.
`define CTRL_RST        5'h00
`define CYCLE_DIV_RST   16'h0031
`define AQ_SRC_RST      5'h04
`define GATE_PREV_RST   4'hF

`endif

//--- logic/cycle_logic.v
// Scan-cycle logic elements: flags, analog outputs, key inputs and eight basic gates.
// Assumes an APB master on clk_sys and inputs synchronous to clk_sys.
`timescale 1ns/10ps
`include "cycle_logic_map.vh"

module cycle_logic (
   // Clock and reset.
   input wire clk_sys,
   input wire rst_b,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Operator keys and message state.
   input wire [3:0] cursor_keys,
   input wire [3:0] func_keys,
   input wire msg_active,
   // Digital inputs usable by gates.
   input wire [3:0] dig_in,
   // Shift register function.
   input wire [7:0] shift_bits_in,
   input wire shift_update,
   // Analog function values, four of 16 bits.
   input wire [63:0] analog_func_in,
   // Outputs.
   output wire onboard_backlight,
   output wire ext_backlight,
   output wire msg_charset,
   output reg [15:0] analog_out_conn0,
   output reg [15:0] analog_out_conn1,
   output reg [7:0] gate_out,
   output wire cycle_tick
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and bus decode.

   reg [4:0] ctrl;
   reg [15:0] cycle_div;
   reg [15:0] div_cnt;
   reg [26:0] flag_next;
   reg [26:0] flag_q;
   reg first_active;
   reg reject;
   reg [7:0] shift_bits;
   reg [4:0] aq0_src;
   reg [4:0] aq1_src;
   reg [95:0] aflag_next;
   reg [95:0] analog_flag;
   reg [23:0] gate_cfg_type;
   reg [255:0] gate_cfg_src;
   reg step_pulse;
   reg restart_pulse;
   reg aq0_bad;
   reg aq1_bad;
   reg next_hit;
   reg [15:0] next_div_cnt;

   wire wr_en;
   wire rd_en;
   wire run;
   wire [26:0] flag_out;
   wire [7:0] cursor_eff;
   wire [3:0] func_eff;
   wire [63:0] src_vec;
   wire aq_wr0;
   wire aq_wr1;
   wire [3:0] gate_idx;
   wire wr_ok;
   wire sel_ctrl;
   wire sel_status;
   wire sel_div;
   wire sel_flag_next;
   wire sel_aflag;
   wire sel_gate;
   wire [7:0] aflag_off;
   wire [2:0] aflag_idx;
   wire [7:0] gate_q;
   wire [31:0] status_word;
   wire [31:0] shift_word;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = (wr_en | rd_en) & ~next_hit;
   assign run = ctrl[`CTRL_RUN];
   assign aq_wr0 = wr_ok & (paddr == `REG_AQ0_SRC);
   assign aq_wr1 = wr_ok & (paddr == `REG_AQ1_SRC);
   assign gate_idx = {1'b0, paddr[5:3]};
   // Analog flag words sit one word apart above their base.
   assign aflag_off = paddr - `REG_AFLAG_BASE;
   assign aflag_idx = aflag_off[4:2];

   ////////////////////////////////////////////////////////////////////////////
   // Write decode. Only mapped, aligned words take a write, so nothing aliases.

   assign wr_ok = wr_en & next_hit;
   assign sel_ctrl = wr_ok & (paddr == `REG_CTRL);
   assign sel_status = wr_ok & (paddr == `REG_STATUS);
   assign sel_div = wr_ok & (paddr == `REG_CYCLE_DIV);
   assign sel_flag_next = wr_ok & (paddr == `REG_FLAG_NEXT);
   assign sel_aflag = wr_ok & (paddr >= `REG_AFLAG_BASE) & (paddr < `REG_AFLAG_END);
   assign sel_gate = wr_ok & (paddr >= `REG_GATE_BASE) & (paddr < `REG_GATE_END);

   ////////////////////////////////////////////////////////////////////////////
   // Program cycle timing: a divider tick in RUN, or a single step.

   assign cycle_tick = (run & (div_cnt == 16'h0000)) | step_pulse;

   // The divider reloads while stopped, so RUN always starts a full program cycle.
   always @* begin
      next_div_cnt = div_cnt - 16'h0001;
      if (!run || div_cnt == 16'h0000) begin
         next_div_cnt = cycle_div;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= `CYCLE_DIV_RST;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags.

   // The startup flag reads high for the whole first cycle, low for the next, then as written.
   assign flag_out = flag_q | ({26'h0, first_active} << `FLAG_STARTUP);

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 27'h0;
         first_active <= 1'b1;
         analog_flag <= 96'h0;
      end else if (restart_pulse) begin
         flag_q <= 27'h0;
         first_active <= 1'b1;
      end else if (cycle_tick) begin
         flag_q <= flag_next;
         analog_flag <= aflag_next;
         first_active <= 1'b0;
         if (first_active) begin
            flag_q[`FLAG_STARTUP] <= 1'b0;
         end
      end
   end

   assign onboard_backlight = flag_out[`FLAG_BL_ONBOARD];
   assign ext_backlight = flag_out[`FLAG_BL_EXT];
   assign msg_charset = ctrl[`CTRL_CS_USED] ? flag_out[`FLAG_CHARSET] : ctrl[`CTRL_CS_CFG];

   ////////////////////////////////////////////////////////////////////////////
   // Shift bits, keys and the source vector for gate inputs.

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shift_bits <= 8'h00;
      end else if (shift_update) begin
         shift_bits <= shift_bits_in;
      end
   end

   assign cursor_eff = {4'h0, cursor_keys & {4{run | msg_active}}};
   assign func_eff = func_keys & {4{run}};

   // Code 0 is open, 1 constant low, 2 constant high.
   assign src_vec = {5'h00, flag_out, dig_in, gate_out, shift_bits, func_eff, cursor_eff[3:0], 4'h4};

   ////////////////////////////////////////////////////////////////////////////
   // Basic gates.

   genvar g;
   generate
      for (g = 0; g < `NUM_GATES; g = g + 1) begin : gates
         wire [31:0] cfg;
         wire [3:0] open;
         wire [3:0] inv;
         wire [3:0] val;
         assign cfg = gate_cfg_src[32*g+31:32*g];
         assign open[0] = (cfg[5:0] == `SRC_OPEN);
         assign open[1] = (cfg[13:8] == `SRC_OPEN);
         assign open[2] = (cfg[21:16] == `SRC_OPEN);
         assign open[3] = (cfg[29:24] == `SRC_OPEN);
         assign inv = {cfg[30], cfg[22], cfg[14], cfg[6]};
         assign val = {src_vec[cfg[29:24]], src_vec[cfg[21:16]], src_vec[cfg[13:8]], src_vec[cfg[5:0]]};
         gate4 u_gate (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .tick(cycle_tick),
            .gate_type(gate_cfg_type[3*g+2:3*g]),
            .in_inv(inv),
            .in_open(open),
            .in_val(val),
            .q(gate_q[g])
         );
      end
   endgenerate

   // One word gathers the eight gate results.
   always @* begin
      gate_out = gate_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog outputs.

   // A source is legal only if it names an analog input, analog flag or output.
   always @* begin
      aq0_bad = 1'b1;
      aq1_bad = 1'b1;
      case (pwdata[1:0])
         `AQ_SRC_FUNC: aq0_bad = (pwdata[4:2] >= `NUM_AFUNC);
         `AQ_SRC_AFLAG: aq0_bad = (pwdata[4:2] >= `NUM_AFLAGS);
         `AQ_SRC_AQ: aq0_bad = (pwdata[4:2] != 3'h0);
         default: aq0_bad = 1'b1;
      endcase
      aq1_bad = aq0_bad;
   end

   function [15:0] aq_pick;
      input [4:0] src;
      input [15:0] other;
      input [63:0] func_v;
      input [95:0] af_v;
      begin
         case (src[1:0])
            `AQ_SRC_FUNC: aq_pick = func_v[16*src[4:2] +: 16];
            `AQ_SRC_AFLAG: aq_pick = af_v[16*src[4:2] +: 16];
            `AQ_SRC_AQ: aq_pick = other;
            default: aq_pick = 16'h0000;
         endcase
      end
   endfunction

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         analog_out_conn0 <= 16'h0000;
         analog_out_conn1 <= 16'h0000;
      end else if (cycle_tick) begin
         analog_out_conn0 <= aq_pick(aq0_src, analog_out_conn1, analog_func_in, analog_flag);
         analog_out_conn1 <= aq_pick(aq1_src, analog_out_conn0, analog_func_in, analog_flag);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes.

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= `CTRL_RST;
         cycle_div <= `CYCLE_DIV_RST;
         flag_next <= 27'h0;
         aflag_next <= 96'h0;
         aq0_src <= `AQ_SRC_RST;
         aq1_src <= `AQ_SRC_RST;
         reject <= 1'b0;
         gate_cfg_type <= 24'h0;
         gate_cfg_src <= 256'h0;
         step_pulse <= 1'b0;
         restart_pulse <= 1'b0;
      end else begin
         step_pulse <= sel_ctrl & pwdata[`CTRL_STEP];
         restart_pulse <= sel_ctrl & pwdata[`CTRL_RESTART];
         if (sel_ctrl) begin
            ctrl <= {pwdata[`CTRL_CS_CFG], pwdata[`CTRL_CS_USED], 2'b00, pwdata[`CTRL_RUN]};
         end
         if (sel_div) begin
            cycle_div <= pwdata[15:0];
         end
         if (sel_flag_next) begin
            flag_next <= pwdata[26:0];
         end
         if (sel_aflag) begin
            aflag_next[16*aflag_idx +: 16] <= pwdata[15:0];
         end
         if (aq_wr0 && !aq0_bad) begin
            aq0_src <= pwdata[4:0];
         end
         if (aq_wr1 && !aq1_bad) begin
            aq1_src <= pwdata[4:0];
         end
         // A refused source sets the sticky flag even in a clearing write.
         if ((aq_wr0 && aq0_bad) || (aq_wr1 && aq1_bad)) begin
            reject <= 1'b1;
         end else if (sel_status && pwdata[`STAT_REJECT]) begin
            reject <= 1'b0;
         end
         if (sel_gate && !paddr[2]) begin
            gate_cfg_type[3*gate_idx +: 3] <= pwdata[2:0];
         end
         if (sel_gate && paddr[2]) begin
            gate_cfg_src[32*gate_idx +: 32] <= pwdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads. The shift register word ignores writes.

   // Key summary bits show the keys as gated, as the gates see them.
   assign status_word = {22'h0, func_eff != 4'h0, cursor_eff[3:0] != 4'h0, 6'h0, reject, first_active};
   assign shift_word = {16'h0, func_eff, cursor_eff[3:0], shift_bits};

   always @* begin
      prdata = 32'h0;
      next_hit = 1'b1;
      if (paddr[1:0] != 2'b00) begin
         next_hit = 1'b0;
      end else if (paddr >= `REG_GATE_BASE && paddr < `REG_GATE_END) begin
         if (paddr[2]) begin
            prdata = gate_cfg_src[32*gate_idx +: 32];
         end else begin
            prdata = {29'h0, gate_cfg_type[3*gate_idx +: 3]};
         end
      end else if (paddr >= `REG_AFLAG_BASE && paddr < `REG_AFLAG_END) begin
         prdata = {16'h0, analog_flag[16*aflag_idx +: 16]};
      end else begin
         case (paddr)
            `REG_CTRL: prdata = {27'h0, ctrl};
            `REG_STATUS: prdata = status_word;
            `REG_CYCLE_DIV: prdata = {16'h0, cycle_div};
            `REG_FLAG_NEXT: prdata = {5'h0, flag_next};
            `REG_FLAG_OUT: prdata = {5'h0, flag_out};
            `REG_SHIFT: prdata = shift_word;
            `REG_AQ0_SRC: prdata = {27'h0, aq0_src};
            `REG_AQ1_SRC: prdata = {27'h0, aq1_src};
            `REG_AQ_VAL: prdata = {analog_out_conn1, analog_out_conn0};
            `REG_GATE_OUT: prdata = {24'h0, gate_out};
            default: next_hit = 1'b0;
         endcase
      end
   end

endmodule

//--- logic/gate4.v
// One four-input basic gate with per-input inversion and edge evaluation.
// Assumes a one-cycle tick that marks the end of each program cycle.
`timescale 1ns/10ps
`include "cycle_logic_map.vh"

module gate4 (
   // Clock and reset.
   input wire clk_sys,
   input wire rst_b,
   input wire tick,
   // Configuration.
   input wire [2:0] gate_type,
   input wire [3:0] in_inv,
   input wire [3:0] in_open,
   // Input levels.
   input wire [3:0] in_val,
   // Result.
   output reg q
);

   reg [3:0] prev;
   reg [3:0] eff;
   reg next_q;
   wire all_one;
   wire prev_all_one;

   // Open inputs count as 0 for OR and 1 for every other gate.
   always @* begin
      eff = (in_val ^ in_inv) & ~in_open;
      if (gate_type != `G_OR) begin
         eff = eff | in_open;
      end
   end

   assign all_one = &eff;
   assign prev_all_one = &prev;

   always @* begin
      case (gate_type)
         `G_AND: next_q = all_one;
         `G_AND_EDGE: next_q = all_one & ~prev_all_one;
         `G_NAND: next_q = ~all_one;
         `G_NAND_EDGE: next_q = ~all_one & prev_all_one;
         `G_OR: next_q = |eff;
         default: next_q = 1'b0;
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= 1'b0;
         prev <= `GATE_PREV_RST;
      end else if (tick) begin
         q <= next_q;
         prev <= eff;
      end
   end

endmodule

//--- test/cycle_logic_sva.sv
// Checker for cycle_logic: flag timing, backlights, character set, shift bits, cycle steps.
// Assumes a bind to cycle_logic; sees only its ports.
`timescale 1ns/10ps
module cycle_logic_sva (
   // Clock and reset.
   input wire clk_sys,
   input wire rst_b,
   // APB.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   // Shift function.
   input wire [7:0] shift_bits_in,
   input wire shift_update,
   // Outputs.
   input wire onboard_backlight,
   input wire ext_backlight,
   input wire msg_charset,
   input wire [15:0] analog_out_conn0,
   input wire [7:0] gate_out,
   input wire cycle_tick
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   wire rd = psel && penable && !pwrite;
   wire ctl_w = psel && penable && pwrite && paddr == 8'h00;
   reg cs_used, cs_cfg, first, rs_d;
   reg [7:0] sh;
   // A restart may move outputs on its own edge and the next one.
   wire quiet = !cycle_tick && !rs_d && !(ctl_w && pwdata[2]);
   ////////////////////////////////////////////////////////////
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cs_used <= 1'b0;
         cs_cfg <= 1'b0;
         first <= 1'b1;
         rs_d <= 1'b0;
         sh <= 8'h00;
      end else begin
         rs_d <= ctl_w && pwdata[2];
         if (ctl_w) begin
            cs_used <= pwdata[3];
            cs_cfg <= pwdata[4];
         end
         if (rs_d)
            first <= 1'b1;
         else if (cycle_tick)
            first <= 1'b0;
         if (shift_update)
            sh <= shift_bits_in;
      end
   end
   ////////////////////////////////////////////////////////////
   AST_STEP_TICK: assert property (ctl_w && pwdata[1] |=> cycle_tick)
      else $error("step write gave no cycle tick");
   AST_GATE_HOLD: assert property (quiet |=> $stable(gate_out))
      else $error("gate outputs moved inside a cycle");
   AST_AQ_HOLD: assert property (quiet |=> $stable(analog_out_conn0))
      else $error("analog output moved inside a cycle");
   AST_BL_HOLD: assert property (quiet |=> $stable({onboard_backlight, ext_backlight}))
      else $error("backlight moved inside a cycle");
   AST_BL_FLAG: assert property (rd && paddr == 8'h10 |-> prdata[25:24] == {ext_backlight, onboard_backlight})
      else $error("backlight pins differ from flags");
   AST_CS_CFG: assert property (!cs_used |-> msg_charset == cs_cfg)
      else $error("stored character set not used");
   AST_CS_FLAG: assert property (rd && paddr == 8'h10 && cs_used |-> msg_charset == prdata[26])
      else $error("character set differs from flag");
   AST_FIRST_FLAG: assert property (rd && paddr == 8'h10 && first |-> prdata[7])
      else $error("startup flag low in first cycle");
   AST_FIRST_STAT: assert property (rd && paddr == 8'h04 |-> prdata[0] == first)
      else $error("first cycle status wrong");
   AST_SHIFT_RO: assert property (rd && paddr == 8'h14 |-> prdata[7:0] == sh)
      else $error("shift bits differ from last capture");
endmodule
bind cycle_logic cycle_logic_sva cycle_logic_sva_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .shift_bits_in(shift_bits_in), .shift_update(shift_update), .onboard_backlight(onboard_backlight),
   .ext_backlight(ext_backlight), .msg_charset(msg_charset), .analog_out_conn0(analog_out_conn0),
   .gate_out(gate_out), .cycle_tick(cycle_tick));

//--- test/panel_model.sv
// Far-side model: operator keys, message state, digital inputs, shift function, analog values.
// Assumes the bench clock; every change lands just after a rising edge.
`timescale 1ns/10ps
module panel_model (
   // Clock.
   input wire clk_sys,
   // Keys and message state.
   output reg [3:0] cursor_keys,
   output reg [3:0] func_keys,
   output reg msg_active,
   // Digital inputs and shift function.
   output reg [3:0] dig_in,
   output reg [7:0] shift_bits_in,
   output reg shift_update,
   // Analog function values.
   output wire [63:0] analog_func_in
);
   assign analog_func_in = 64'h4444_3333_2222_1111;
   initial begin
      cursor_keys = 4'h0;
      func_keys = 4'h0;
      msg_active = 1'b0;
      dig_in = 4'h0;
      shift_bits_in = 8'h00;
      shift_update = 1'b0;
   end
   task keys(input [3:0] cur, input [3:0] fk, input msg);
      @(posedge clk_sys);
      cursor_keys <= cur;
      func_keys <= fk;
      msg_active <= msg;
   endtask
   task din(input [3:0] val);
      @(posedge clk_sys);
      dig_in <= val;
   endtask
   // The data lines show the inverse once the capture strobe is gone.
   task shift(input [7:0] val);
      @(posedge clk_sys);
      shift_bits_in <= val;
      shift_update <= 1'b1;
      @(posedge clk_sys);
      shift_update <= 1'b0;
      shift_bits_in <= ~val;
   endtask
endmodule

//--- test/test_cycle_logic.sv
// Bench for cycle_logic: APB tasks step program cycles against the panel model.
// Assumes an APB slave that answers when it is ready; a watchdog ends a hung run.
`timescale 1ns/10ps
module test_cycle_logic;
   reg clk_sys, rst_b, psel, penable, pwrite, rerr;
   reg [7:0] paddr, g;
   reg [31:0] pwdata, rdat, ctl;
   reg [3:0] v, c, p;
   wire pready, pslverr, msg_active, shift_update, onboard_backlight, ext_backlight, msg_charset, cycle_tick;
   wire [31:0] prdata;
   wire [3:0] cursor_keys, func_keys, dig_in;
   wire [7:0] shift_bits_in, gate_out;
   wire [63:0] analog_func_in;
   wire [15:0] analog_out_conn0, analog_out_conn1;
   integer fails, checks_done, i, n;
   localparam [35:0] seq_din = 36'h711545055;
   cycle_logic cycle_logic_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .cursor_keys(cursor_keys), .func_keys(func_keys), .msg_active(msg_active), .dig_in(dig_in),
      .shift_bits_in(shift_bits_in), .shift_update(shift_update), .analog_func_in(analog_func_in),
      .onboard_backlight(onboard_backlight), .ext_backlight(ext_backlight), .msg_charset(msg_charset),
      .analog_out_conn0(analog_out_conn0), .analog_out_conn1(analog_out_conn1), .gate_out(gate_out),
      .cycle_tick(cycle_tick));
   panel_model panel_model_inst (.clk_sys(clk_sys), .cursor_keys(cursor_keys), .func_keys(func_keys),
      .msg_active(msg_active), .dig_in(dig_in), .shift_bits_in(shift_bits_in), .shift_update(shift_update),
      .analog_func_in(analog_func_in));
   ////////////////////////////////////////////////////////////
   // Ends after the falling edge so that pins read next are settled.
   task apb(input w, input [7:0] a, input [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk_sys);
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task rdchk(input [7:0] a, input [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   task step;
      apb(1'b1, 8'h00, ctl | 32'h2);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   function [5:0] gexp(input [3:0] cur, input [3:0] old);
      gexp = {1'b1, |cur[2:0], !(&cur) && (&old), !(&cur), (&cur) && !(&old), &cur};
   endfunction
   task wrap_up;
      $display("checks=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #400000;
      fails = fails + 1;
      wrap_up;
   end
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata, ctl} = 0;
      fails = 0;
      checks_done = 0;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      rdchk(8'h00, 32'h0);
      rdchk(8'h08, 32'h31);
      rdchk(8'h04, 32'h1);
      rdchk(8'h10, 32'h80);
      rdchk(8'h18, 32'h4);
      apb(1'b0, 8'hFC, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h0C, 32'h0700_0081);
      rdchk(8'h10, 32'h80);
      chk({30'h0, onboard_backlight, ext_backlight}, 32'h0);
      step;
      rdchk(8'h10, 32'h0700_0001);
      rdchk(8'h04, 32'h0);
      chk({29'h0, onboard_backlight, ext_backlight, msg_charset}, 32'h6);
      ctl = 32'h8;
      apb(1'b1, 8'h00, ctl);
      chk({31'h0, msg_charset}, 32'h1);
      apb(1'b1, 8'h0C, 32'h80);
      step;
      rdchk(8'h10, 32'h80);
      chk({29'h0, onboard_backlight, ext_backlight, msg_charset}, 32'h0);
      ctl = 32'h10;
      apb(1'b1, 8'h00, ctl);
      chk({31'h0, msg_charset}, 32'h1);
      panel_model_inst.shift(8'hA5);
      apb(1'b1, 8'h14, 32'hFF);
      rdchk(8'h14, 32'hA5);
      apb(1'b1, 8'h18, 32'h3);
      apb(1'b1, 8'h1C, 32'h6);
      rdchk(8'h18, 32'h4);
      rdchk(8'h04, 32'h2);
      apb(1'b1, 8'h04, 32'h2);
      rdchk(8'h04, 32'h0);
      apb(1'b1, 8'h18, 32'h1);
      apb(1'b1, 8'h24, 32'h1234);
      rdchk(8'h24, 32'h0);
      step;
      chk({analog_out_conn0, analog_out_conn1}, 32'h0000_2222);
      rdchk(8'h24, 32'h1234);
      apb(1'b1, 8'h1C, 32'h2);
      rdchk(8'h1C, 32'h2);
      for (g = 8'h0; g < 8'h6; g = g + 8'h1) begin
         apb(1'b1, 8'h80 + (g << 3), {29'h0, g == 8'h5 ? 3'h0 : g[2:0]});
         apb(1'b1, 8'h84 + (g << 3), g == 8'h5 ? 32'h0041_0202 : 32'h001E_5D1C);
      end
      apb(1'b1, 8'hB0, 32'h4);
      apb(1'b1, 8'hB4, 32'h0804);
      step;
      chk({analog_out_conn0, analog_out_conn1}, 32'h1234_0000);
      p = 4'hA;
      for (i = 0; i < 9; i = i + 1) begin
         v = seq_din[i * 4 +: 4];
         panel_model_inst.din(v);
         c = {1'b1, v[2], ~v[1], v[0]};
         step;
         chk({24'h0, gate_out}, {24'h0, 2'b10, gexp(c, p)});
         p = c;
      end
      panel_model_inst.keys(4'h1, 4'h0, 1'b1);
      step;
      chk({31'h0, gate_out[6]}, 32'h1);
      panel_model_inst.keys(4'h1, 4'h1, 1'b0);
      step;
      chk({31'h0, gate_out[6]}, 32'h0);
      apb(1'b1, 8'h00, ctl | 32'h4);
      rdchk(8'h10, 32'h80);
      rdchk(8'h04, 32'h1);
      step;
      rdchk(8'h10, 32'h0);
      rdchk(8'h04, 32'h0);
      apb(1'b1, 8'h08, 32'h3);
      ctl = 32'h11;
      apb(1'b1, 8'h00, ctl);
      repeat (60) @(posedge clk_sys);
      n = 0;
      repeat (40) begin
         @(posedge clk_sys);
         n = n + cycle_tick;
      end
      chk(n, 32'hA);
      chk({31'h0, gate_out[6]}, 32'h1);
      rdchk(8'h04, 32'h300);
      rdchk(8'h14, 32'h11A5);
      ctl = 32'h10;
      apb(1'b1, 8'h00, ctl);
      wrap_up;
   end
endmodule
